// ### include/qdp_pkg.sv
// Constants, types and helpers for the quad 64-position pot serial control block.
// Assumes one core clock domain plus the serial clock as a second domain.
// What this block does
// - Read data leaves on the serial output, changing on each falling serial clock edge.
// - Every opcode, address and data bit is sampled on the rising serial clock edge.
// - Chip select high deselects the device and floats the serial output.
// - After power-up nothing is accepted until chip select has gone high then low.
// - While paused the serial sequence state is kept and the command continues afterwards.
// - Two bus select pins form the address low bits; mismatch ends the command.
// - Write-guard pin low blocks nonvolatile setting writes.
// - Serial output is three-state and driven only while returning read data.
// - At most one tap switch per channel is ever enabled.
// - Six wiper counter bits decode to a one-hot select of sixty-four taps.
// - Four independent wiper counters, one per channel.
// - Write-wiper instruction loads a wiper counter from serial data.
// - Single or global transfer loads wiper counters from a chosen setting slot.
// - Increment/decrement moves a wiper counter by one position per step and holds it at either end.
// - Power-up loads each wiper counter from its setting slot zero.
// - Four 6-bit setting slots per channel, readable and writable by the host.
// - Transfers run both ways between any setting slot and its wiper counter.
// - Any setting slot change is a nonvolatile write lasting at most 10ms.
// - Instruction byte is 4-bit opcode, 2-bit slot index, 2-bit channel index.
// - Save starts on chip select rise after a complete write; pending flag is readable.
// - Incdec: pulse with input high steps toward upper end, low toward lower end.
// - First byte holds device type code, two reserved zero bits, two bus select bits.
package qdp_pkg;

    // Instruction opcodes, top nibble of the instruction byte
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'ha;
    localparam logic [3:0] OP_RD_SLOT = 4'hb;
    localparam logic [3:0] OP_WR_SLOT = 4'hc;
    localparam logic [3:0] OP_XFR_SLOT_TO_WIPER = 4'hd;
    localparam logic [3:0] OP_XFR_WIPER_TO_SLOT = 4'he;
    localparam logic [3:0] OP_GXFR_SLOT_TO_WIPER = 4'h1;
    localparam logic [3:0] OP_GXFR_WIPER_TO_SLOT = 4'h8;
    localparam logic [3:0] OP_INCDEC = 4'h2;
    localparam logic [3:0] OP_RD_STATUS = 4'h5;

    // Byte field positions
    localparam int OPCODE_LSB = 4;
    localparam int SLOT_IDX_LSB = 2;
    localparam int CHAN_IDX_LSB = 0;
    localparam int DEV_TYPE_LSB = 4;

    // Sizes and reset values
    localparam int CHANNELS = 4;
    localparam int SLOTS = 4;
    localparam int POS_W = 6;
    localparam int TAPS = 64;
    localparam logic [5:0] POS_MIN = 6'h00;
    localparam logic [5:0] POS_MAX = 6'h3f;
    localparam logic [5:0] SLOT_RESET = 6'h00;

    // Nonvolatile write time and its count at the core clock rate
    localparam int NV_WRITE_TIME_MS = 10;
    localparam int CLK_FREQ_KHZ = 250000;
    localparam int NV_WRITE_CYCLES_DFLT = NV_WRITE_TIME_MS * CLK_FREQ_KHZ;
    localparam int NV_TIMER_W = 22;

    // Serial sequence states, one-hot
    typedef enum logic [5:0] {
        ST_ID = 6'h01,
        ST_INSTR = 6'h02,
        ST_DATA = 6'h04,
        ST_READ = 6'h08,
        ST_INCDEC = 6'h10,
        ST_IGNORE = 6'h20
    } qdp_state_e;

    // Gray code helpers for the incdec position crossing
    function automatic logic [5:0] qdp_bin2gray(input logic [5:0] b);
        qdp_bin2gray = b ^ {1'b0, b[5:1]};
    endfunction

    function automatic logic [5:0] qdp_gray2bin(input logic [5:0] g);
        logic [5:0] b;
        b[5] = g[5];
        for (int i = 4; i >= 0; i--)
        begin
            b[i] = b[i + 1] ^ g[i];
        end
        qdp_gray2bin = b;
    endfunction

endpackage

// ### src/qdp_serial_pot.sv
// Serial control logic of a four-channel, 64-position digital potentiometer.
// Assumes a core clock with power-up style reset and a host-driven serial clock.
`timescale 1ns/1ps

module qdp_serial_pot
    import qdp_pkg::*;
#(
    parameter logic [3:0] DEVICE_TYPE_CODE = 4'h3, // Arbitrary value
    parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DFLT
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    input wire logic hold_n_in,
    input wire logic wp_n_in,
    input wire logic [1:0] bus_select_pins_in,
    output logic [CHANNELS*POS_W-1:0] wiper_position_out,
    output logic [CHANNELS*TAPS-1:0] tap_select_out,
    output logic nv_write_pending_out
);

    // Per-frame serial state, cleared whenever chip select is high
    typedef struct packed {
        qdp_state_e state;
        logic [2:0] cnt;
        logic [6:0] shreg;
        logic [3:0] op;
        logic [1:0] rsel;
        logic [1:0] psel;
        logic [7:0] tx;
        logic [1:0] bsel1;
        logic [1:0] bsel2;
        logic [1:0] bsel3;
        logic [1:0] bsel_f;
        logic wip1;
        logic wip2;
        logic wip3;
        logic wip_f;
    } qdp_frame_s;

    // Serial-side words that must outlive the frame
    typedef struct packed {
        logic tgl;
        logic [3:0] op;
        logic [1:0] rsel;
        logic [1:0] psel;
        logic [5:0] data;
        logic [5:0] gray;
    } qdp_keep_s;

    // Falling-edge output stage
    typedef struct packed {
        logic so;
        logic oe;
    } qdp_tx_s;

    // Core domain state
    typedef struct packed {
        logic cs1;
        logic cs2;
        logic cs3;
        logic csn_f;
        logic tg1;
        logic tg2;
        logic tg3;
        logic tgl_f;
        logic tgl_seen;
        logic wp1;
        logic wp2;
        logic wp3;
        logic wp_f;
        logic [5:0] gr1;
        logic [5:0] gr2;
        logic [5:0] gr3;
        logic [5:0] gray_f;
        logic seen_high;
        logic armed;
        logic recall;
        logic [CHANNELS-1:0][5:0] wiper;
        logic [CHANNELS-1:0][SLOTS-1:0][5:0] slot;
        logic staged;
        logic [CHANNELS-1:0] stage_mask;
        logic [1:0] stage_r;
        logic [CHANNELS-1:0][5:0] stage_data;
        logic pending;
        logic [NV_TIMER_W-1:0] timer;
        logic incdec_on;
        logic [1:0] incdec_ch;
    } qdp_core_s;

    qdp_frame_s fr_reg;
    qdp_frame_s fr_next;
    qdp_keep_s kp_reg;
    qdp_keep_s kp_next;
    qdp_tx_s tx_reg;
    qdp_tx_s tx_next;
    qdp_core_s core_reg;
    qdp_core_s core_next;

    logic frame_rst;
    logic keep_rst;
    logic [7:0] byte_v;
    logic fire;
    logic [5:0] fire_data;
    logic load_gray;
    logic cs_rise;
    logic new_cmd;
    logic [5:0] step_pos;

    // Frame logic held in reset while deselected or before the first chip select fall; kept words only before that fall
    assign frame_rst = cs_n_in | ~core_reg.armed;
    assign keep_rst = ~core_reg.armed;
    assign byte_v = {fr_reg.shreg, sdi_in};

    // Rising-edge serial decode: ID byte, instruction byte, data or read phase
    always_comb
    begin
        fr_next = fr_reg;
        fire = 1'b0;
        fire_data = 6'h00;
        load_gray = 1'b0;
        fr_next.bsel1 = bus_select_pins_in;
        fr_next.bsel2 = fr_reg.bsel1;
        fr_next.bsel3 = fr_reg.bsel2;
        if (fr_reg.bsel2 == fr_reg.bsel3)
        begin
            fr_next.bsel_f = fr_reg.bsel3;
        end
        fr_next.wip1 = core_reg.pending;
        fr_next.wip2 = fr_reg.wip1;
        fr_next.wip3 = fr_reg.wip2;
        if (fr_reg.wip2 == fr_reg.wip3)
        begin
            fr_next.wip_f = fr_reg.wip3;
        end
        if (hold_n_in)
        begin
            fr_next.shreg = byte_v[6:0];
            fr_next.cnt = fr_reg.cnt + 3'h1;
            case (fr_reg.state)
                ST_ID:
                begin
                    if (fr_reg.cnt == 3'h7)
                    begin
                        if (byte_v[7:DEV_TYPE_LSB] == DEVICE_TYPE_CODE && byte_v[1:0] == fr_reg.bsel_f)
                            fr_next.state = ST_INSTR;
                        else
                            fr_next.state = ST_IGNORE;
                    end
                end
                ST_INSTR:
                begin
                    if (fr_reg.cnt == 3'h7)
                    begin
                        fr_next.op = byte_v[7:OPCODE_LSB];
                        fr_next.rsel = byte_v[SLOT_IDX_LSB +: 2];
                        fr_next.psel = byte_v[CHAN_IDX_LSB +: 2];
                        fr_next.state = ST_IGNORE;
                        case (byte_v[7:OPCODE_LSB])
                            OP_RD_WIPER:
                            begin
                                fr_next.tx = {2'b00, core_reg.wiper[byte_v[1:0]]};
                                fr_next.state = ST_READ;
                            end
                            OP_RD_SLOT:
                            begin
                                fr_next.tx = {2'b00, core_reg.slot[byte_v[1:0]][byte_v[3:2]]};
                                fr_next.state = ST_READ;
                            end
                            OP_RD_STATUS:
                            begin
                                fr_next.tx = {7'h00, fr_reg.wip_f};
                                fr_next.state = ST_READ;
                            end
                            OP_WR_WIPER, OP_WR_SLOT:
                            begin
                                fr_next.state = ST_DATA;
                            end
                            OP_XFR_SLOT_TO_WIPER, OP_XFR_WIPER_TO_SLOT, OP_GXFR_SLOT_TO_WIPER, OP_GXFR_WIPER_TO_SLOT:
                            begin
                                fire = 1'b1;
                            end
                            OP_INCDEC:
                            begin
                                fire = 1'b1;
                                load_gray = 1'b1;
                                fr_next.state = ST_INCDEC;
                            end
                            default:
                            begin
                                fr_next.state = ST_IGNORE;
                            end
                        endcase
                    end
                end
                ST_DATA:
                begin
                    if (fr_reg.cnt == 3'h7)
                    begin
                        fire = 1'b1; // Only a full data byte completes the write
                        fire_data = byte_v[5:0];
                        fr_next.state = ST_IGNORE;
                    end
                end
                ST_READ:
                begin
                    fr_next.tx = {fr_reg.tx[6:0], 1'b0};
                    if (fr_reg.cnt == 3'h7)
                    begin
                        fr_next.state = ST_IGNORE;
                    end
                end
                ST_INCDEC, ST_IGNORE:
                begin
                    fr_next.state = fr_reg.state;
                end
                default:
                begin
                    fr_next.state = ST_IGNORE;
                end
            endcase
        end
    end

    // Command hand-off toggle with held fields, and the incdec position in gray code
    always_comb
    begin
        kp_next = kp_reg;
        step_pos = qdp_gray2bin(kp_reg.gray);
        if (hold_n_in)
        begin
            if (fire)
            begin
                kp_next.tgl = ~kp_reg.tgl;
                kp_next.op = (fr_reg.state == ST_DATA) ? fr_reg.op : byte_v[7:OPCODE_LSB];
                kp_next.rsel = (fr_reg.state == ST_DATA) ? fr_reg.rsel : byte_v[SLOT_IDX_LSB +: 2];
                kp_next.psel = (fr_reg.state == ST_DATA) ? fr_reg.psel : byte_v[CHAN_IDX_LSB +: 2];
                kp_next.data = fire_data;
            end
            if (load_gray)
            begin
                kp_next.gray = qdp_bin2gray(core_reg.wiper[byte_v[1:0]]);
            end
            else if (fr_reg.state == ST_INCDEC)
            begin
                if (sdi_in && step_pos != POS_MAX)
                    kp_next.gray = qdp_bin2gray(step_pos + 6'h01);
                else if (!sdi_in && step_pos != POS_MIN)
                    kp_next.gray = qdp_bin2gray(step_pos - 6'h01);
            end
        end
    end

    // Output stage updates on the falling edge and floats outside read data
    always_comb
    begin
        tx_next = tx_reg;
        if (hold_n_in && fr_reg.state == ST_READ)
        begin
            tx_next.so = fr_reg.tx[7];
            tx_next.oe = 1'b1;
        end
        else
        begin
            tx_next.oe = 1'b0;
        end
    end

    // Serial domain registers
    always_ff @(posedge sck_in or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            fr_reg <= '0;
            fr_reg.state <= ST_ID;
        end
        else
        begin
            fr_reg <= fr_next;
        end
    end

    always_ff @(posedge sck_in or posedge keep_rst)
    begin
        if (keep_rst)
            kp_reg <= '0;
        else
            kp_reg <= kp_next;
    end

    always_ff @(negedge sck_in or posedge frame_rst)
    begin
        if (frame_rst)
            tx_reg <= '0;
        else
            tx_reg <= tx_next;
    end

    // Core: synchronisers, command execution, staged saves and the write timer
    always_comb
    begin
        core_next = core_reg;
        cs_rise = 1'b0;
        new_cmd = 1'b0;
        if (!rst_n_in)
        begin
            core_next = '0;
            core_next.recall = 1'b1;
            for (int ch = 0; ch < CHANNELS; ch++)
            begin
                for (int s = 0; s < SLOTS; s++)
                begin
                    core_next.slot[ch][s] = SLOT_RESET;
                end
            end
        end
        else
        begin
            core_next.cs1 = cs_n_in;
            core_next.cs2 = core_reg.cs1;
            core_next.cs3 = core_reg.cs2;
            if (core_reg.cs2 == core_reg.cs3)
                core_next.csn_f = core_reg.cs3;
            core_next.tg1 = kp_reg.tgl;
            core_next.tg2 = core_reg.tg1;
            core_next.tg3 = core_reg.tg2;
            if (core_reg.tg2 == core_reg.tg3)
                core_next.tgl_f = core_reg.tg3;
            core_next.wp1 = wp_n_in;
            core_next.wp2 = core_reg.wp1;
            core_next.wp3 = core_reg.wp2;
            if (core_reg.wp2 == core_reg.wp3)
                core_next.wp_f = core_reg.wp3;
            core_next.gr1 = kp_reg.gray;
            core_next.gr2 = core_reg.gr1;
            core_next.gr3 = core_reg.gr2;
            if (core_reg.gr2 == core_reg.gr3)
                core_next.gray_f = core_reg.gr3;
            cs_rise = core_next.csn_f & ~core_reg.csn_f;
            // Arm only after a real high-to-low chip select transition
            if (core_next.csn_f)
                core_next.seen_high = 1'b1;
            if (core_reg.seen_high && !core_next.csn_f)
                core_next.armed = 1'b1;
            if (core_reg.recall)
            begin
                core_next.recall = 1'b0;
                for (int ch = 0; ch < CHANNELS; ch++)
                begin
                    core_next.wiper[ch] = core_reg.slot[ch][0];
                end
            end
            if (core_reg.pending)
            begin
                core_next.timer = core_reg.timer - 1'b1;
                if (core_reg.timer == '0)
                    core_next.pending = 1'b0;
            end
            // Fields from the serial side are stable for several cycles before the toggle lands
            core_next.tgl_seen = core_next.tgl_f;
            new_cmd = (core_next.tgl_f != core_reg.tgl_seen) && core_reg.armed && !core_reg.pending;
            if (new_cmd)
            begin
                case (kp_reg.op)
                    OP_WR_WIPER:
                    begin
                        core_next.wiper[kp_reg.psel] = kp_reg.data;
                    end
                    OP_XFR_SLOT_TO_WIPER:
                    begin
                        core_next.wiper[kp_reg.psel] = core_reg.slot[kp_reg.psel][kp_reg.rsel];
                    end
                    OP_GXFR_SLOT_TO_WIPER:
                    begin
                        for (int ch = 0; ch < CHANNELS; ch++)
                        begin
                            core_next.wiper[ch] = core_reg.slot[ch][kp_reg.rsel];
                        end
                    end
                    OP_WR_SLOT, OP_XFR_WIPER_TO_SLOT:
                    begin
                        core_next.staged = 1'b1;
                        core_next.stage_r = kp_reg.rsel;
                        core_next.stage_mask = 4'h1 << kp_reg.psel;
                        core_next.stage_data[kp_reg.psel] = (kp_reg.op == OP_WR_SLOT) ? kp_reg.data
                                                             : core_reg.wiper[kp_reg.psel];
                    end
                    OP_GXFR_WIPER_TO_SLOT:
                    begin
                        core_next.staged = 1'b1;
                        core_next.stage_r = kp_reg.rsel;
                        core_next.stage_mask = 4'hf;
                        core_next.stage_data = core_reg.wiper;
                    end
                    OP_INCDEC:
                    begin
                        core_next.incdec_on = 1'b1;
                        core_next.incdec_ch = kp_reg.psel;
                    end
                    default:
                    begin
                        core_next.staged = core_reg.staged;
                    end
                endcase
            end
            // Follow the stepped position while the incdec frame lasts
            if (core_reg.incdec_on)
            begin
                core_next.wiper[core_reg.incdec_ch] = qdp_gray2bin(core_next.gray_f);
                if (cs_rise)
                    core_next.incdec_on = 1'b0;
            end
            // Save staged slot data once chip select rises
            if (cs_rise && core_next.staged)
            begin
                core_next.staged = 1'b0;
                if (core_next.wp_f)
                begin
                    for (int ch = 0; ch < CHANNELS; ch++)
                    begin
                        if (core_next.stage_mask[ch])
                            core_next.slot[ch][core_next.stage_r] = core_next.stage_data[ch];
                    end
                    core_next.pending = 1'b1;
                    core_next.timer = NV_TIMER_W'(NV_WRITE_CYCLES - 1);
                end
            end
        end
    end

    // Core register; reset acts even while the clock enable is low
    always_ff @(posedge clk_in)
    begin
        if (clk_en_in || !rst_n_in)
            core_reg <= core_next;
    end

    // Per-channel wiper outputs and one-hot tap decode
    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
        assign wiper_position_out[ch*POS_W +: POS_W] = core_reg.wiper[ch];
        assign tap_select_out[ch*TAPS +: TAPS] = {{(TAPS-1){1'b0}}, 1'b1} << core_reg.wiper[ch];
    end

    assign sdo_out = tx_reg.so;
    assign sdo_oe_out = tx_reg.oe;
    assign nv_write_pending_out = core_reg.pending;

endmodule

// ### testbench/qdp_serial_pot_monitor.sv
// Checker of the pot block ports: tap decode, serial output enable, save timing.
// Assumes it is bound to each instance of the serial pot block.
`timescale 1ns/1ps
module qdp_serial_pot_monitor
    import qdp_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DFLT
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,
    input wire logic wp_n_in,
    input wire logic sdo_oe_out,
    input wire logic [CHANNELS*POS_W-1:0] wiper_position_out,
    input wire logic [CHANNELS*TAPS-1:0] tap_select_out,
    input wire logic nv_write_pending_out
);
    logic [31:0] pend_cnt_reg;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Counts the cycles of the current save
    always_ff @(posedge clk_in)
    begin
        pend_cnt_reg <= (rst_n_in && nv_write_pending_out) ? pend_cnt_reg + 32'h1 : 32'h0;
    end
    AST_TAP_ONEHOT:
        assert property ($onehot(tap_select_out[63:0]) && $onehot(tap_select_out[127:64])
            && $onehot(tap_select_out[191:128]) && $onehot(tap_select_out[255:192])) else $error("tap not one-hot");
    AST_TAP_DECODE:
        assert property (tap_select_out[{2'd0, wiper_position_out[5:0]}] && tap_select_out[{2'd1, wiper_position_out[11:6]}]
            && tap_select_out[{2'd2, wiper_position_out[17:12]}] && tap_select_out[{2'd3, wiper_position_out[23:18]}])
        else $error("tap does not follow wiper");
    AST_SDO_FLOAT_DESELECTED:
        assert property (cs_n_in |-> !sdo_oe_out) else $error("output driven while deselected");
    AST_SDO_ONLY_IN_FRAME:
        assert property (sdo_oe_out |-> !cs_n_in && !$past(cs_n_in, 8)) else $error("output driven outside read");
    AST_WIPER_POWER_UP:
        assert property (disable iff (1'b0) !rst_n_in |=> wiper_position_out == 24'h0) else $error("wiper not slot zero");
    AST_SAVE_LENGTH:
        assert property ($fell(nv_write_pending_out) && $past(rst_n_in) |->
            pend_cnt_reg <= NV_WRITE_CYCLES && 2 * pend_cnt_reg > NV_WRITE_CYCLES) else $error("save length wrong");
    AST_SAVE_CAUSE:
        assert property ($rose(nv_write_pending_out) |-> $past(cs_n_in, 2) && wp_n_in) else $error("save without cause");
    AST_WIPER_QUIET:
        assert property ($changed(wiper_position_out) && $past(rst_n_in) |-> !cs_n_in || !$past(cs_n_in, 7))
        else $error("wiper moved without command");
endmodule
bind qdp_serial_pot qdp_serial_pot_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_qdp_serial_pot_monitor (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .wp_n_in(wp_n_in), .sdo_oe_out(sdo_oe_out),
    .wiper_position_out(wiper_position_out), .tap_select_out(tap_select_out),
    .nv_write_pending_out(nv_write_pending_out));

// ### testbench/qdp_host_model.sv
// Host serial master model for the pot block.
// Assumes one xfer call per chip-select frame; serial clock idles low.
`timescale 1ns/1ps
module qdp_host_model
(
    output logic sck_out,
    output logic cs_n_out,
    output logic sdi_out,
    output logic hold_n_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_in
);
    // Idle levels
    initial
    begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b1;
        hold_n_out = 1'b1;
    end
    // n bits MSB first, pause with dummy pulses before bit p, returned bits in rd
    task automatic xfer(input logic [23:0] d, input int n, input int p, output logic [7:0] rd);
        rd = 8'h00;
        cs_n_out = 1'b0;
        #30;
        for (int i = 0; i < n; i++)
        begin
            if (i == p)
            begin
                hold_n_out = 1'b0;
                repeat (2)
                begin
                    sdi_out = ~d[23 - i];
                    #3 sck_out = 1'b1;
                    #3 sck_out = 1'b0;
                end
                hold_n_out = 1'b1;
            end
            sdi_out = d[23 - i];
            #3 sck_out = 1'b1;
            rd = {rd[6:0], sdo_oe_in ? sdo_in : 1'bz};
            #3 sck_out = 1'b0;
        end
        #3 cs_n_out = 1'b1;
        sdi_out = ~sdi_out;
        #60;
    endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench of the pot serial control block.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
module testbench
    import qdp_pkg::*;
;
    localparam logic [3:0] TYPE_CODE = 4'h6; // Arbitrary value
    logic clk_in, rst_n_in, wp_n, sck, cs_n, sdi, hold_n, sdo, sdo_oe, pend;
    logic [1:0] bus_sel;
    logic [23:0] wiper;
    logic [255:0] taps;
    logic [7:0] rd;
    logic [7:0] id_byte;
    int failures = 0;
    int checks = 0;
    // Core clock
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    qdp_serial_pot #(.DEVICE_TYPE_CODE(TYPE_CODE), .NV_WRITE_CYCLES(200)) i_qdp_serial_pot (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .sck_in(sck), .cs_n_in(cs_n), .sdi_in(sdi),
        .sdo_out(sdo), .sdo_oe_out(sdo_oe), .hold_n_in(hold_n), .wp_n_in(wp_n), .bus_select_pins_in(bus_sel),
        .wiper_position_out(wiper), .tap_select_out(taps), .nv_write_pending_out(pend));
    qdp_host_model i_qdp_host_model (.sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi), .hold_n_out(hold_n),
        .sdo_in(sdo), .sdo_oe_in(sdo_oe));
    // Compare and count
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One frame without pause
    task automatic run(input logic [7:0] ins, input logic [7:0] dat, input int n);
        i_qdp_host_model.xfer({id_byte, ins, dat}, n, -1, rd);
    endtask
    // Waits for a save to end
    task automatic settle();
        for (int i = 0; i < 400 && pend !== 1'b0; i++)
            @(posedge clk_in);
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #100000;
        failures++;
        results();
    end
    // Test sequence
    initial
    begin
        rst_n_in = 1'b0;
        wp_n = 1'b1;
        bus_sel = 2'b10;
        id_byte = {TYPE_CODE, 2'b00, 2'b10};
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        // Let the chip select filter see the idle high level before the first frame arms the device
        repeat (8) @(posedge clk_in);
        chk("reset wipers", 24'h0, wiper);
        $display("test reset done");
        for (int c = 0; c < 4; c++)
        begin
            run({OP_WR_WIPER, 2'b00, 2'(c)}, {2'b11, 6'(60 + c)}, 24);
            chk("wiper", 24'(60 + c), 24'(wiper[c*6 +: 6]));
            chk("tap", 24'h1, 24'(taps[c*64 + 60 + c]));
        end
        i_qdp_host_model.xfer({id_byte, OP_RD_WIPER, 4'h2, 8'h00}, 24, 11, rd);
        chk("paused read", 24'h3e, 24'(rd));
        $display("test wiper done");
        run({OP_GXFR_WIPER_TO_SLOT, 4'h4}, 8'h00, 16);
        run({OP_RD_STATUS, 4'h1}, 8'h00, 24);
        chk("status busy", 24'h1, 24'(rd));
        settle();
        run({OP_RD_STATUS, 4'h1}, 8'h00, 24);
        chk("status idle", 24'h0, 24'(rd));
        run({OP_WR_WIPER, 4'h0}, 8'h05, 24);
        run({OP_GXFR_SLOT_TO_WIPER, 4'h4}, 8'h00, 16);
        chk("global restore", {6'h3f, 6'h3e, 6'h3d, 6'h3c}, wiper);
        $display("test transfer done");
        run({OP_WR_SLOT, 4'hd}, 8'h15, 24);
        settle();
        @(posedge clk_in);
        wp_n <= 1'b0;
        run({OP_WR_SLOT, 4'hd}, 8'h0a, 24);
        chk("guarded pending", 24'h0, 24'(pend));
        wp_n <= 1'b1;
        run({OP_RD_SLOT, 4'hd}, 8'h00, 24);
        chk("slot", 24'h15, 24'(rd));
        run({OP_XFR_SLOT_TO_WIPER, 4'hd}, 8'h00, 16);
        chk("slot to wiper", 24'h15, 24'(wiper[11:6]));
        run({OP_XFR_WIPER_TO_SLOT, 4'h9}, 8'h00, 16);
        settle();
        run({OP_RD_SLOT, 4'h9}, 8'h00, 24);
        chk("wiper to slot", 24'h15, 24'(rd));
        $display("test slot done");
        run({OP_INCDEC, 4'h3}, 8'hc0, 24);
        chk("incdec", 24'h39, 24'(wiper[23:18]));
        id_byte = {TYPE_CODE, 2'b00, 2'b01};
        run({OP_WR_WIPER, 4'h0}, 8'h01, 24);
        chk("wrong address", 24'h3c, 24'(wiper[5:0]));
        id_byte = {TYPE_CODE, 2'b00, 2'b10};
        run({OP_XFR_WIPER_TO_SLOT, 4'h1}, 8'h00, 16);
        settle();
        run({OP_GXFR_SLOT_TO_WIPER, 4'h0}, 8'h00, 16);
        chk("slot zero restore", 24'h000540, wiper);
        $display("test incdec and address done");
        results();
    end
endmodule
